// file: shared/jlt_pkg.sv
// Purpose: shared constants and types for the link initialization transmit controller
// Assumes: one 20 MHz device clock; frame clock and LMFC are enables derived from it
// Notes:   link configuration values describe a single-lane, two-octet-frame link
package jlt_pkg;
  // timing
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          FRAME_DIV       = 4;       // device clocks per frame clock
  localparam int          SYSREF_DLY      = 1;       // sysref-to-lmfc delay, device clocks
  localparam logic [1:0]  FR_ALIGN_POS    = 2'(SYSREF_DLY);
  localparam logic [1:0]  FR_LOAD         = 2'(SYSREF_DLY + 1);
  localparam logic [1:0]  FR_LAST         = 2'(FRAME_DIV - 1);
  localparam int          SYNC_MIN_FRAMES = 4;
  localparam int          ILA_MFRAMES     = 4;
  localparam logic [1:0]  ILA_LAST_MF     = 2'(ILA_MFRAMES - 1);
  localparam int          PLL_CAL_SAMPLES = 153000;  // sampling clocks = device clocks here
  localparam int          PLL_CNT_W       = 18;
  // line symbols
  localparam logic [7:0]  SYM_K28_5       = 8'hbc;
  localparam logic [7:0]  SYM_K28_0       = 8'h1c;
  localparam logic [7:0]  SYM_K28_3       = 8'h7c;
  localparam logic [7:0]  SYM_K28_4       = 8'h9c;
  localparam logic [14:0] SCR_SEED        = 15'h7fff;
  // link configuration octet fields
  localparam int          CFG_OCTETS      = 14;
  localparam logic [4:0]  CFG_L_M1        = 5'h00;
  localparam logic [7:0]  CFG_F_M1        = 8'h01;
  localparam logic [7:0]  CFG_M_M1        = 8'h00;
  localparam logic [4:0]  CFG_N_M1        = 5'h0f;
  localparam logic [4:0]  CFG_NP_M1       = 5'h0f;
  localparam logic [2:0]  CFG_SUBCLASSV   = 3'h1;
  localparam logic [2:0]  CFG_JESDV       = 3'h1;
  localparam logic [4:0]  CFG_S_M1        = 5'h00;
  // status bit positions
  localparam int          ST_CLK_RDY      = 0;
  localparam int          ST_CAL_DONE     = 1;
  localparam int          ST_PLL_LOCK     = 2;
  localparam int          ST_ALIGN        = 3;
  localparam int          ST_REALIGN      = 4;
  localparam int          ST_SYNC         = 5;
  localparam int          ST_LINK         = 6;

  typedef enum logic [2:0] {
    JLT_SLEEP,
    JLT_CORE_CAL,
    JLT_PLL_CAL,
    JLT_CGS,
    JLT_ILA,
    JLT_DATA
  } jlt_state_t;
endpackage

// file: rtl/jlt_sync_filter.sv
// Purpose: synchronise the sync request pin and filter short low pulses
// Assumes: frame_en_i is a one-cycle pulse per frame clock
// Notes:   request rises after the pin stays low for MIN_FRAMES frame clocks
`timescale 1ns/100ps
module jlt_sync_filter #(
  parameter int MIN_FRAMES = jlt_pkg::SYNC_MIN_FRAMES
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  // pin and frame enable
  input  wire logic sync_request_n_i,
  input  wire logic frame_en_i,
  // filtered request, active high
  output logic      req_o
);
  import jlt_pkg::*;

  logic [2:0] pin_reg;
  logic       lvl_reg;
  logic [2:0] low_cnt_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_reg <= 3'h7;
    end else begin
      pin_reg <= {pin_reg[1:0], sync_request_n_i};
    end
  end

  // only the second and third stages are compared, never the first
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lvl_reg <= 1'b1;
    end else if (pin_reg[1] == pin_reg[2]) begin
      lvl_reg <= pin_reg[2];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_cnt_reg <= 3'h0;
      req_o       <= 1'b0;
    end else if (lvl_reg) begin
      low_cnt_reg <= 3'h0;
      req_o       <= 1'b0;
    end else if (frame_en_i && low_cnt_reg != 3'(MIN_FRAMES)) begin
      low_cnt_reg <= low_cnt_reg + 3'h1;
    end else if (low_cnt_reg == 3'(MIN_FRAMES)) begin
      req_o       <= 1'b1;
    end
  end
endmodule

// file: rtl/jlt_buf2.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock
// Notes:   in_ready_o is registered, so a full buffer stalls the source at once
`timescale 1ns/100ps
module jlt_buf2 #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  // fill side
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // drain side
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] mem [2];
  logic         rd_ptr_reg;
  logic         wr_ptr_reg;
  logic [1:0]   cnt_reg;
  logic [1:0]   cnt_next;
  logic         push;
  logic         pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = cnt_reg != 2'h0;
  assign out_data_o  = mem[rd_ptr_reg];

  always_comb begin
    cnt_next = cnt_reg + 2'(push) - 2'(pop);
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
      in_ready_o <= 1'b0;
    end else begin
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      wr_ptr_reg <= wr_ptr_reg ^ push;
      cnt_reg    <= cnt_next;
      in_ready_o <= cnt_next != 2'h2;
    end
  end
endmodule

// file: rtl/jlt_link_tx.sv
// Purpose: transmit-side link initialization and data framing for one serial lane
// Assumes: sysref and sync request arrive from pins; controls come from this clock domain
// Notes:   one 16-bit sample per frame, sent as two octets with per-octet control flags
`timescale 1ns/100ps
module jlt_link_tx #(
  parameter int PLL_CAL_CYCLES = jlt_pkg::PLL_CAL_SAMPLES
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // link pins
  input  wire logic        sysref_i,
  input  wire logic        sync_request_n_i,
  // device control
  input  wire logic        core_cal_done_i,
  input  wire logic        sleep_i,
  input  wire logic        power_down_i,
  input  wire logic        scramble_en_i,
  input  wire logic [4:0]  k_m1_i,
  // sample stream
  input  wire logic [15:0] smp_data_i,
  input  wire logic        smp_valid_i,
  output logic             smp_ready_o,
  // lane symbols
  output logic [15:0]      lane_data_o,
  output logic [1:0]       lane_ctrl_o,
  output logic             lane_stb_o,
  // status
  output logic [7:0]       link_status_register_o,
  output logic             core_cal_req_o
);
  import jlt_pkg::*;

  jlt_state_t           state_reg;
  jlt_state_t           state_next;
  logic [1:0]           frame_cnt_reg;
  logic [4:0]           lmfc_cnt_reg;
  logic [1:0]           ila_mf_reg;
  logic [PLL_CNT_W-1:0] pll_cnt_reg;
  logic [2:0]           sysref_reg;
  logic                 sysref_lvl_reg;
  logic                 pd_seen_reg;
  logic                 aligned_reg;
  logic                 realigned_reg;
  logic [14:0]          scr_reg;
  logic                 frame_en;
  logic                 lmfc_edge;
  logic                 sysref_edge;
  logic                 sysref_ok;
  logic                 realign;
  logic                 low_power;
  logic                 restart;
  logic                 pll_done;
  logic                 sync_req;
  logic [15:0]          buf_data;
  logic                 buf_valid;
  logic                 buf_pop;

  function automatic logic [7:0] cfg_raw(input int idx, input logic [4:0] k_m1,
                                         input logic scr);
    logic [7:0] v;
    case (idx)
      3:       v = {scr, 2'h0, CFG_L_M1};
      4:       v = CFG_F_M1;
      5:       v = {3'h0, k_m1};
      6:       v = CFG_M_M1;
      7:       v = {3'h0, CFG_N_M1};
      8:       v = {CFG_SUBCLASSV, CFG_NP_M1};
      9:       v = {CFG_JESDV, CFG_S_M1};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] cfg_octet(input int idx, input logic [4:0] k_m1,
                                           input logic scr);
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < CFG_OCTETS - 1; i++) begin
      sum = sum + cfg_raw(i, k_m1, scr);
    end
    return (idx == CFG_OCTETS - 1) ? sum : cfg_raw(idx, k_m1, scr);
  endfunction

  // one octet of the alignment sequence: {control flag, octet}
  function automatic logic [8:0] ila_octet(input logic [1:0] mf, input logic [4:0] fr,
                                           input int p, input logic [4:0] k_m1,
                                           input logic scr);
    int         idx;
    logic [8:0] v;
    idx = 2 * int'(fr) + p - 3;
    v   = {1'b0, 8'(2 * int'(fr) + p)};
    if (fr == 5'h00 && p == 0) begin
      v = {1'b1, SYM_K28_0};
    end else if (fr == k_m1 && p == 1) begin
      v = {1'b1, SYM_K28_3};
    end else if (mf == 2'h1 && fr == 5'h01 && p == 0) begin
      v = {1'b1, SYM_K28_4};
    end else if (mf == 2'h1 && idx >= 0 && idx < CFG_OCTETS) begin
      v = {1'b0, cfg_octet(idx, k_m1, scr)};
    end
    return v;
  endfunction

  // self-synchronous scrambler 1 + x^14 + x^15, msb first
  function automatic logic [30:0] scramble(input logic [15:0] d, input logic [14:0] st);
    logic [14:0] s;
    logic [15:0] o;
    s = st;
    o = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      o[i] = d[i] ^ s[13] ^ s[14];
      s    = {s[13:0], o[i]};
    end
    return {s, o};
  endfunction

  jlt_sync_filter #(
    .MIN_FRAMES (SYNC_MIN_FRAMES)
  ) u_sync (
    .ref_clk_i        (ref_clk_i),
    .resetn_i         (resetn_i),
    .sync_request_n_i (sync_request_n_i),
    .frame_en_i       (frame_en),
    .req_o            (sync_req)
  );

  // a stalled lane keeps up to two samples; the source sees ready drop
  jlt_buf2 #(
    .W (16)
  ) u_buf (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .in_data_i   (smp_data_i),
    .in_valid_i  (smp_valid_i),
    .in_ready_o  (smp_ready_o),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop)
  );

  assign low_power = sleep_i || power_down_i;
  assign restart   = state_reg == JLT_SLEEP && !low_power;
  assign frame_en  = frame_cnt_reg == FR_LAST;
  assign lmfc_edge = frame_en && lmfc_cnt_reg == k_m1_i;
  assign pll_done  = pll_cnt_reg == PLL_CNT_W'(PLL_CAL_CYCLES - 1);
  assign buf_pop   = state_reg == JLT_DATA && frame_en;

  // sysref pin: three stages, level changes once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sysref_reg <= 3'h0;
    end else begin
      sysref_reg <= {sysref_reg[1:0], sysref_i};
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sysref_lvl_reg <= 1'b0;
    end else if (sysref_reg[1] == sysref_reg[2]) begin
      sysref_lvl_reg <= sysref_reg[2];
    end
  end

  assign sysref_edge = sysref_reg[1] == sysref_reg[2] && sysref_reg[2] && !sysref_lvl_reg;
  // edges are only trusted while the lane is up or training
  assign sysref_ok   = state_reg == JLT_CGS || state_reg == JLT_ILA
                    || state_reg == JLT_DATA;
  // lmfc misaligned but frame clock aligned leaves both untouched
  assign realign     = sysref_edge && sysref_ok
                    && frame_cnt_reg != FR_ALIGN_POS;

  // frame clock and lmfc run from reset with arbitrary phase
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_cnt_reg <= 2'h0;
      lmfc_cnt_reg  <= 5'h00;
    end else if (restart) begin
      frame_cnt_reg <= 2'h0;
      lmfc_cnt_reg  <= 5'h00;
    end else if (realign) begin
      frame_cnt_reg <= FR_LOAD;
      lmfc_cnt_reg  <= 5'h00;
    end else begin
      frame_cnt_reg <= frame_en ? 2'h0 : frame_cnt_reg + 2'h1;
      if (lmfc_edge) begin
        lmfc_cnt_reg <= 5'h00;
      end else if (frame_en) begin
        lmfc_cnt_reg <= lmfc_cnt_reg + 5'h01;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      JLT_SLEEP: begin
        if (!low_power) begin
          state_next = pd_seen_reg ? JLT_CORE_CAL : JLT_PLL_CAL;
        end
      end
      JLT_CORE_CAL: begin
        if (core_cal_done_i) begin
          state_next = JLT_PLL_CAL;
        end
      end
      JLT_PLL_CAL: begin
        if (pll_done) begin
          state_next = JLT_CGS;
        end
      end
      JLT_CGS: begin
        if (lmfc_edge && !sync_req) begin
          state_next = JLT_ILA;
        end
      end
      JLT_ILA: begin
        if (lmfc_edge && ila_mf_reg == ILA_LAST_MF) begin
          state_next = JLT_DATA;
        end
      end
      JLT_DATA: begin
        state_next = JLT_DATA;
      end
      default: begin
        state_next = JLT_SLEEP;
      end
    endcase
    if (state_reg == JLT_ILA || state_reg == JLT_DATA) begin
      if (sync_req) begin
        state_next = JLT_CGS;
      end
    end
    if (realign) begin
      state_next = JLT_PLL_CAL;
    end
    if (low_power) begin
      state_next = JLT_SLEEP;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= JLT_CORE_CAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // power-down remembered so its exit recalibrates the core; sleep does not
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pd_seen_reg <= 1'b0;
    end else if (power_down_i) begin
      pd_seen_reg <= 1'b1;
    end else if (restart) begin
      pd_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pll_cnt_reg <= '0;
    end else if (state_reg != JLT_PLL_CAL || realign) begin
      pll_cnt_reg <= '0;
    end else if (!pll_done) begin
      pll_cnt_reg <= pll_cnt_reg + PLL_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ila_mf_reg <= 2'h0;
    end else if (state_reg != JLT_ILA) begin
      ila_mf_reg <= 2'h0;
    end else if (lmfc_edge) begin
      ila_mf_reg <= ila_mf_reg + 2'h1;
    end
  end

  // lane symbols, one frame per frame clock
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lane_data_o <= 16'h0000;
      lane_ctrl_o <= 2'h0;
      lane_stb_o  <= 1'b0;
      scr_reg     <= SCR_SEED;
    end else begin
      lane_stb_o <= frame_en && state_reg != JLT_SLEEP && state_reg != JLT_CORE_CAL;
      if (frame_en) begin
        case (state_reg)
          JLT_PLL_CAL, JLT_CGS: begin
            lane_data_o <= {SYM_K28_5, SYM_K28_5};
            lane_ctrl_o <= 2'h3;
            scr_reg     <= SCR_SEED;
          end
          JLT_ILA: begin
            // config octets go out plain whatever the scrambler setting
            {lane_ctrl_o[1], lane_data_o[15:8]} <=
              ila_octet(ila_mf_reg, lmfc_cnt_reg, 0, k_m1_i, scramble_en_i);
            {lane_ctrl_o[0], lane_data_o[7:0]} <=
              ila_octet(ila_mf_reg, lmfc_cnt_reg, 1, k_m1_i, scramble_en_i);
          end
          JLT_DATA: begin
            lane_ctrl_o <= 2'h0;
            if (scramble_en_i) begin
              {scr_reg, lane_data_o} <= scramble(buf_valid ? buf_data : 16'h0000,
                                                 scr_reg);
            end else begin
              lane_data_o <= buf_valid ? buf_data : 16'h0000;
            end
          end
          default: begin
            lane_data_o <= 16'h0000;
            lane_ctrl_o <= 2'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aligned_reg   <= 1'b0;
      realigned_reg <= 1'b0;
    end else begin
      if (realign) begin
        aligned_reg   <= 1'b1;
        realigned_reg <= 1'b1;
      end else if (sysref_edge && sysref_ok) begin
        aligned_reg   <= 1'b1;
      end else if (state_reg == JLT_DATA) begin
        realigned_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_status_register_o <= 8'h00;
      core_cal_req_o         <= 1'b1;
    end else begin
      core_cal_req_o                      <= state_next == JLT_CORE_CAL;
      link_status_register_o[7]           <= 1'b0;
      link_status_register_o[ST_CLK_RDY]  <= state_reg != JLT_SLEEP;
      link_status_register_o[ST_CAL_DONE] <= state_reg != JLT_SLEEP
                                          && state_reg != JLT_CORE_CAL;
      link_status_register_o[ST_PLL_LOCK] <= state_reg == JLT_CGS
                                          || state_reg == JLT_ILA
                                          || state_reg == JLT_DATA;
      link_status_register_o[ST_ALIGN]    <= aligned_reg;
      link_status_register_o[ST_REALIGN]  <= realigned_reg;
      link_status_register_o[ST_SYNC]     <= (state_reg == JLT_ILA
                                          || state_reg == JLT_DATA) && !sync_req;
      link_status_register_o[ST_LINK]     <= state_reg == JLT_DATA;
    end
  end
endmodule

// file: sim/jlt_link_tx_sva.sv
// Purpose: port-level checks for the link transmit controller
// Assumes: one clock domain; status bits as laid out in the package
// Notes:   cause_reg excuses a link drop for 100 cycles after a cause is seen
`timescale 1ns/100ps
module jlt_link_tx_sva
  import jlt_pkg::*;
#(
  parameter int PLL_CAL_CYCLES = PLL_CAL_SAMPLES
) (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  // watched inputs
  input wire logic        sysref_i,
  input wire logic        sync_request_n_i,
  input wire logic        core_cal_done_i,
  input wire logic        sleep_i,
  input wire logic        power_down_i,
  // watched outputs
  input wire logic [15:0] lane_data_o,
  input wire logic [1:0]  lane_ctrl_o,
  input wire logic        lane_stb_o,
  input wire logic [7:0]  link_status_register_o,
  input wire logic        core_cal_req_o
);
  logic [17:0] pll_cnt_reg;
  logic [5:0]  low_cnt_reg;
  logic [6:0]  cause_reg;
  logic        pll_run;
  logic        comma;
  assign pll_run = link_status_register_o[0] && !link_status_register_o[2] && !core_cal_req_o;
  assign comma   = lane_data_o == {SYM_K28_5, SYM_K28_5} && lane_ctrl_o == 2'b11;
  // pin-side counts only: internal phase is unknown here, so drops are excused, not timed
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pll_cnt_reg <= 18'h0;
      low_cnt_reg <= 6'h0;
      cause_reg   <= 7'h0;
    end else begin
      pll_cnt_reg <= pll_run ? pll_cnt_reg + 18'h1 : 18'h0;
      low_cnt_reg <= sync_request_n_i ? 6'h0 : low_cnt_reg + {5'h0, low_cnt_reg != 6'h3f};
      cause_reg   <= (low_cnt_reg > 6'h8 || sysref_i || sleep_i || power_down_i) ? 7'h64
                   : cause_reg - {6'h0, cause_reg != 7'h0};
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  a_stb_period: assert property (
    lane_stb_o && cause_reg == 7'h0 |=> !lane_stb_o [*3] ##1 (lane_stb_o || cause_reg != 7'h0))
    else $error("frame strobe off period");
  a_pll_comma: assert property (
    lane_stb_o && pll_run && $past(pll_run) |-> comma)
    else $error("no comma during pll calibration");
  a_cgs_comma: assert property (
    lane_stb_o && low_cnt_reg >= 6'd40 |-> comma)
    else $error("no comma under sync request");
  a_pll_length: assert property (
    $rose(link_status_register_o[2]) |->
      pll_cnt_reg >= PLL_CAL_CYCLES - 4 && pll_cnt_reg <= PLL_CAL_CYCLES + 4)
    else $error("pll calibration length wrong");
  a_sync_break: assert property (
    low_cnt_reg == 6'd32 |-> !link_status_register_o[6])
    else $error("long sync request kept link");
  a_drop_cause: assert property (
    $fell(link_status_register_o[6]) |-> cause_reg != 7'h0)
    else $error("link dropped without cause");
  a_data_after_ila: assert property (
    $rose(link_status_register_o[6]) |-> link_status_register_o[2] && link_status_register_o[5])
    else $error("data without sync and lock");
  a_sleep_quiet: assert property (
    sleep_i [*3] |-> !lane_stb_o && !link_status_register_o[0])
    else $error("lane active in sleep");
  a_cal_req_hold: assert property (
    core_cal_req_o && !core_cal_done_i && !sleep_i && !power_down_i |=> core_cal_req_o)
    else $error("calibration request dropped early");
  a_pd_recal: assert property (
    $fell(power_down_i) |-> ##[1:4] core_cal_req_o)
    else $error("no calibration after power-down");
endmodule

bind jlt_link_tx jlt_link_tx_sva #(.PLL_CAL_CYCLES(PLL_CAL_CYCLES)) u_sva (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sysref_i(sysref_i),
  .sync_request_n_i(sync_request_n_i), .core_cal_done_i(core_cal_done_i),
  .sleep_i(sleep_i), .power_down_i(power_down_i), .lane_data_o(lane_data_o),
  .lane_ctrl_o(lane_ctrl_o), .lane_stb_o(lane_stb_o),
  .link_status_register_o(link_status_register_o), .core_cal_req_o(core_cal_req_o));

// file: sim/jlt_rx_model.sv
// Purpose: receiver model that drives the sync request pin
// Assumes: commas are 0xbcbc with both control flags set
// Notes:   clock recovery lock is modelled as eight clean comma frames
`timescale 1ns/100ps
module jlt_rx_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // lane from the transmitter
  input  wire logic [15:0] lane_data_i,
  input  wire logic [1:0]  lane_ctrl_i,
  input  wire logic        lane_stb_i,
  // bench commands
  input  wire logic        resync_i,
  input  wire logic        glitch_i,
  // request pin
  output logic             sync_request_n_o
);
  logic       hold_reg;
  logic [2:0] comma_reg;
  // eight commas keep the pin low far beyond four frames
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_reg  <= 1'b1;
      comma_reg <= 3'h0;
    end else if (resync_i) begin
      hold_reg  <= 1'b1;
      comma_reg <= 3'h0;
    end else if (hold_reg && lane_stb_i && lane_ctrl_i == 2'b11 && lane_data_i == 16'hbcbc) begin
      hold_reg  <= comma_reg != 3'h7;
      comma_reg <= comma_reg + 3'h1;
    end
  end
  // glitch pulls the pin straight low; the bench keeps it short on purpose
  assign sync_request_n_o = !(hold_reg || glitch_i);
endmodule

// file: sim/tb.sv
// Purpose: self-checking bench for the link transmit controller
// Assumes: receiver model on the sync pin; short pll calibration
// Notes:   data checks model the 1 + x^14 + x^15 scrambler, flag taken at the launch edge
`timescale 1ns/100ps
module tb;
  import jlt_pkg::*;
  localparam int         PLL_N = 40;
  localparam logic [4:0] KM1   = 5'h08;
  localparam int         FPM   = KM1 + 1;
  logic        ref_clk_i, resetn_i, sysref_i, sync_n, cal_done, sleep, pdown, scr;
  logic        smp_valid, smp_ready, lane_stb, cal_req, resync, glitch, pend_v, scr_q;
  logic [15:0] smp_data, lane_data, pend, w;
  logic [14:0] ss;
  logic [15:0] q[$];
  logic [1:0]  lane_ctrl;
  logic [7:0]  st;
  int          bad_count, checked, phase, n, i, j;
  jlt_link_tx #(.PLL_CAL_CYCLES(PLL_N)) dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sysref_i(sysref_i),
    .sync_request_n_i(sync_n), .core_cal_done_i(cal_done), .sleep_i(sleep),
    .power_down_i(pdown), .scramble_en_i(scr), .k_m1_i(KM1), .smp_data_i(smp_data),
    .smp_valid_i(smp_valid), .smp_ready_o(smp_ready), .lane_data_o(lane_data),
    .lane_ctrl_o(lane_ctrl), .lane_stb_o(lane_stb), .link_status_register_o(st),
    .core_cal_req_o(cal_req));
  jlt_rx_model rx (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .lane_data_i(lane_data),
    .lane_ctrl_i(lane_ctrl), .lane_stb_i(lane_stb), .resync_i(resync),
    .glitch_i(glitch), .sync_request_n_o(sync_n));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge ref_clk_i);
    #2;
  endtask
  task automatic wait_st(input int b, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && st[b] !== v; k++) step(1);
    check(st[b], v);
  endtask
  // valid and data hold until the edge that finds ready high
  task automatic push(input logic [15:0] d);
    smp_valid = 1'b1;
    smp_data  = d;
    @(posedge ref_clk_i);
    while (smp_ready !== 1'b1) @(posedge ref_clk_i);
    #2;
  endtask
  // frame monitor; a push is modelled one edge late, as the buffer shows it
  always @(posedge ref_clk_i) begin
    if (resetn_i && lane_stb) begin
      if (lane_ctrl == 2'b11) begin
        phase = 0;
        ss    = SCR_SEED;
      end else if (phase == 0) begin
        check({lane_ctrl[1], lane_data[15:8]}, {1'b1, SYM_K28_0});
        phase = 1;
        n = 1;
      end else if (phase == 1) begin
        n++;
        if (n == FPM + 4) check(lane_data[15:8], {scr, 7'h0});
        if (n == FPM + 5) check(lane_data[15:8], 8'(KM1));
        if (n == 4 * FPM) begin
          check({lane_ctrl, lane_data[7:0]}, {2'b01, SYM_K28_3});
          phase = 2;
        end
      end else begin
        w = (q.size() > 0) ? q.pop_front() : 16'h0;
        // scrambler state restarts at every comma frame, as on the line
        for (j = 15; j >= 0 && scr_q; j--) begin
          w[j] = w[j] ^ ss[13] ^ ss[14];
          ss   = {ss[13:0], w[j]};
        end
        check({lane_ctrl, lane_data}, {2'b00, w});
      end
    end
    if (pend_v) q.push_back(pend);
    pend_v = smp_valid && smp_ready && resetn_i;
    pend   = smp_data;
    scr_q  = scr;
  end
  initial begin
    #1000000;
    bad_count++;
    conclude;
  end
  initial begin
    {sysref_i, cal_done, sleep, pdown, scr, smp_valid, resync, glitch, pend_v} = '0;
    {resetn_i, smp_data, bad_count, checked, phase, n} = '0;
    void'($urandom(32'h4075));
    step(16);
    check({st, cal_req}, 9'h001);
    resetn_i = 1'b1;
    for (i = 0; i < 3; i++) begin
      smp_valid = 1'b1;
      smp_data  = 16'($urandom);
      step(1);
    end
    smp_valid = 1'b0;
    step(1);
    check(smp_ready, 1'b0);
    cal_done = 1'b1;
    wait_st(2, 1'b1, PLL_N + 20);
    wait_st(6, 1'b1, 800);
    for (i = 0; i < 200; i++) begin
      if ($urandom % 3 != 0) push(16'($urandom));
      else begin
        smp_valid = 1'b0;
        step(1);
      end
    end
    smp_valid = 1'b0;
    step(40);
    glitch = 1'b1;
    step(8);
    glitch = 1'b0;
    step(40);
    check(st[6], 1'b1);
    resync = 1'b1;
    step(1);
    resync = 1'b0;
    wait_st(6, 1'b0, 40);
    wait_st(6, 1'b1, 1000);
    // sysref only with the link up; pulse two lands two clocks off any frame phase
    sysref_i = 1'b1;
    step(4);
    sysref_i = 1'b0;
    step(398);
    sysref_i = 1'b1;
    step(4);
    sysref_i = 1'b0;
    step(8);
    check(st[6], 1'b0);
    check(st[4], 1'b1);
    step(388);
    check(st[6], 1'b1);
    sysref_i = 1'b1;
    step(4);
    sysref_i = 1'b0;
    step(60);
    check(st[6:3], 4'b1101);
    sleep = 1'b1;
    step(10);
    check(st[0], 1'b0);
    sleep = 1'b0;
    step(4);
    check(cal_req, 1'b0);
    wait_st(6, 1'b1, 800);
    scr      = 1'b1;
    cal_done = 1'b0;
    pdown    = 1'b1;
    step(10);
    pdown = 1'b0;
    step(20);
    check({cal_req, st[2:1]}, 3'b100);
    cal_done = 1'b1;
    wait_st(6, 1'b1, 800);
    step(40);
    conclude;
  end
endmodule
